// ==== verilog/cw_pkg.sv ====
// Constants, types and decode helpers for charge cycle and watchdog control
// What this block does
// [RULE1] Power-on: default mode, registers at defaults
// [RULE2] Default safety time expiry opens battery switch
// [RULE3] Kick write enters host mode, flag low
// [RULE4] Host disables watchdog or kicks before expiry
// [RULE5] Each kick restarts the watchdog count
// [RULE6] Expiry sets flag, default mode, defaults
// [RULE7] Charge only with enable bit and pin low
// [RULE8] Default voltage, currents, profile and safety time
// [RULE9] Start needs converter, no faults, permit, low battery
// [RULE10] Recharge below target minus selected offset
// [RULE11] Enable toggle after finish starts new cycle
// [RULE12] Terminate on voltage and current, not limited
// [RULE13] Phase code encodes seven charge phases
// [RULE14] Phase change pulses alert low unless masked
// [RULE15] Start phase chosen from battery voltage
// [RULE16] Limit mode: less current, no termination, half rate
// [RULE17] Termination opens switch unless supplement; converter runs
// [RULE18] Termination disable bit prevents any termination
// [RULE19] Top-off keeps charging, code 101 then 110
// [RULE20] Top-off timer pauses and slows with safety timer
// [RULE21] Top-off reset on enable, termination, register reset
// [RULE22] Top-off duration captured at termination detection
// [RULE23] Watchdog periods and alert width are parameters
package cw_pkg;
	localparam int TW = 32;
	localparam int VW = 14;
	localparam int IW = 12;
	localparam int CLK_NS = 10;
	localparam int TICK_NS = 1_000_000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int SAFETY_TENTHS_H = 165;
	localparam int TICKS_PER_TENTH_H = 360_000;
	localparam int SAFETY_TICKS = SAFETY_TENTHS_H * TICKS_PER_TENTH_H;
	localparam int ALERT_NS = 2560;
	localparam int ALERT_CYC = (ALERT_NS + CLK_NS - 1) / CLK_NS;
	localparam int WD_T1_S = 40;
	localparam int WD_T2_S = 80;
	localparam int WD_T3_S = 160;
	localparam int TOP_T1_MIN = 15;
	localparam int TOP_T2_MIN = 30;
	localparam int TOP_T3_MIN = 45;
	localparam int TICKS_PER_S = 1000;
	localparam logic [VW-1:0] CHARGE_VOLTAGE_TARGET_RST = 14'h20d0;
	localparam logic [IW-1:0] ICHG_RST = 12'h3e8;
	localparam logic [IW-1:0] IPRE_RST = 12'h096;
	localparam logic [IW-1:0] ITERM_RST = 12'h096;
	localparam logic [IW-1:0] ISHORT_MA = 12'h046;
	localparam logic [VW-1:0] RECH_OFS_LO = 14'h0064;
	localparam logic [VW-1:0] RECH_OFS_HI = 14'h00c8;
	localparam logic [1:0] WD_SEL_RST = 2'h1;
	localparam logic [1:0] RECH_SEL_RST = 2'h0;
	localparam logic [1:0] TOP_SEL_RST = 2'h0;
	localparam logic CHG_EN_RST = 1'h1;
	localparam logic TERM_EN_RST = 1'h1;
	localparam logic MASK_RST = 1'h0;
	localparam logic TEMP_EN_RST = 1'h1;
	localparam logic [2:0] CODE_IDLE = 3'h0;
	localparam logic [2:0] CODE_TRK = 3'h1;
	localparam logic [2:0] CODE_PRE = 3'h2;
	localparam logic [2:0] CODE_FAST = 3'h3;
	localparam logic [2:0] CODE_TAPER = 3'h4;
	localparam logic [2:0] CODE_TOP = 3'h5;
	localparam logic [2:0] CODE_DONE = 3'h6;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_TRK   = 7'h02,
		ST_PRE   = 7'h04,
		ST_FAST  = 7'h08,
		ST_TAPER = 7'h10,
		ST_TOP   = 7'h20,
		ST_DONE  = 7'h40
	} cw_phase_e;

	function automatic logic [2:0] cw_code(input cw_phase_e p);
		unique case (p)
			ST_TRK:   cw_code = CODE_TRK;
			ST_PRE:   cw_code = CODE_PRE;
			ST_FAST:  cw_code = CODE_FAST;
			ST_TAPER: cw_code = CODE_TAPER;
			ST_TOP:   cw_code = CODE_TOP;
			ST_DONE:  cw_code = CODE_DONE;
			default:  cw_code = CODE_IDLE;
		endcase
	endfunction : cw_code

	function automatic logic cw_charging(input cw_phase_e p);
		cw_charging = (p != ST_IDLE) && (p != ST_DONE);
	endfunction : cw_charging

	function automatic logic [TW-1:0] cw_sel_ticks(input logic [1:0] s,
			input int t1, input int t2, input int t3, input int unit);
		unique case (s)
			2'h1:    cw_sel_ticks = TW'(t1 * unit);
			2'h2:    cw_sel_ticks = TW'(t2 * unit);
			2'h3:    cw_sel_ticks = TW'(t3 * unit);
			default: cw_sel_ticks = '0;
		endcase
	endfunction : cw_sel_ticks
endpackage : cw_pkg

// ==== verilog/cw_tmr_if.sv ====
// Control and status bundle between the controller and a tick timer
`timescale 1ns/1ns
interface cw_tmr_if;
	logic                  clr;
	logic                  run;
	logic                  half;
	logic [cw_pkg::TW-1:0] limit;
	logic                  expired;
	modport ctl (output clr, output run, output half, output limit,
		input expired);
	modport tmr (input clr, input run, input half, input limit,
		output expired);
endinterface : cw_tmr_if

// ==== verilog/cw_timer.sv ====
// Pausable tick timer with half-rate counting
`timescale 1ns/1ns
module cw_timer #(
	parameter int P_TICK_CYC = cw_pkg::TICK_CYC
) (
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_sys_rst,
	// Timer control
	cw_tmr_if.tmr     t
);
	import cw_pkg::*;
	localparam int PW = (P_TICK_CYC > 1) ? $clog2(P_TICK_CYC) : 1;
	logic [PW-1:0] pre_r;
	logic          half_ph_r;
	logic [TW-1:0] cnt_r;
	logic          step;
	logic          tick;

	generate
		if (P_TICK_CYC < 2) begin : g_chk
			$error("cw_timer: P_TICK_CYC must be at least 2");
		end
	endgenerate

	// Half rate skips every other cycle
	assign step = t.run && (!t.half || half_ph_r);
	assign tick = step && (pre_r == PW'(P_TICK_CYC - 1));
	assign t.expired = (cnt_r == t.limit);

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			half_ph_r <= 1'b0;
		else if (t.clr)
			half_ph_r <= 1'b0;
		else if (t.run && t.half)
			half_ph_r <= !half_ph_r;
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			pre_r <= '0;
		else if (t.clr || tick)
			pre_r <= '0;
		else if (step)
			pre_r <= pre_r + PW'(1);
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			cnt_r <= '0;
		else if (t.clr)
			cnt_r <= '0;
		else if (tick && !t.expired)
			cnt_r <= cnt_r + TW'(1);
	end
endmodule : cw_timer

// ==== verilog/cw_top.sv ====
// Charge cycle sequencing, phase status, alert and watchdog control
`timescale 1ns/1ns
module cw_top #(
	parameter int              P_TICK_CYC     = cw_pkg::TICK_CYC,
	parameter int              P_SAFETY_TICKS = cw_pkg::SAFETY_TICKS,
	parameter int              P_ALERT_CYC    = cw_pkg::ALERT_CYC,
	parameter logic [13:0]     P_VSHORT_MV    = 14'h0bb8,
	parameter logic [13:0]     P_VLOW_MV      = 14'h1770
) (
	// Clock and reset
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_sys_rst,
	// Pin and analog status
	input  wire logic                   i_charge_off_pin,
	input  wire logic                   i_conv_ok,
	input  wire logic                   i_thermistor_fault,
	input  wire logic                   i_reg_limit,
	input  wire logic                   i_supplement,
	input  wire logic [cw_pkg::VW-1:0]  i_vbat_mv,
	input  wire logic [cw_pkg::IW-1:0]  i_ichg_ma,
	// Host writes
	input  wire logic                   i_watchdog_kick,
	input  wire logic                   i_register_reset_bit,
	input  wire logic                   i_cfg_wr,
	input  wire logic                   i_cfg_charge_enable_bit,
	input  wire logic [1:0]             i_cfg_recharge_offset_sel,
	input  wire logic                   i_cfg_termination_enable,
	input  wire logic                   i_cfg_phase_alert_mask,
	input  wire logic [1:0]             i_cfg_watchdog_period_sel,
	input  wire logic [1:0]             i_cfg_topoff_sel,
	input  wire logic                   i_cfg_temp_profile_en,
	input  wire logic [cw_pkg::VW-1:0]  i_cfg_charge_voltage_target,
	input  wire logic [cw_pkg::IW-1:0]  i_cfg_ichg_ma,
	input  wire logic [cw_pkg::IW-1:0]  i_cfg_iprechg_ma,
	input  wire logic [cw_pkg::IW-1:0]  i_cfg_iterm_ma,
	// Status and control out
	output logic [2:0]                  o_charge_phase_code,
	output logic                        o_host_alert_pin_n,
	output logic                        o_battery_switch_on,
	output logic                        o_conv_run,
	output logic                        o_watchdog_expired_flag,
	output logic                        o_host_mode,
	output logic                        o_safety_fault,
	output logic                        o_temp_profile_en,
	output logic [cw_pkg::VW-1:0]       o_charge_voltage_target_mv,
	output logic [cw_pkg::IW-1:0]       o_ichg_target_ma
);
	import cw_pkg::*;

	cw_phase_e      phase_r, phase_nxt;
	logic [2:0]     sync_r;
	logic           off_q_r, off_prev_r;
	logic           host_mode_r, safety_fault_r, rearm_r;
	logic           chg_en_r, term_en_r, mask_r, temp_en_r;
	logic [1:0]     rech_sel_r, wd_sel_r, top_sel_r;
	logic [VW-1:0]  charge_voltage_target_r;
	logic [IW-1:0]  ichg_r, ipre_r, iterm_r;
	logic [TW-1:0]  top_lim_r;
	logic [TW-1:0]  alert_cnt_r;
	logic           permit, start_ok, wd_exp, safety_exp, top_exp;
	logic           term_det, alert_trig;
	logic [VW-1:0]  rech_thr;
	logic [IW-1:0]  iset;
	cw_phase_e      start_ph;

	cw_tmr_if safety_if ();
	cw_tmr_if top_if ();
	cw_tmr_if wd_if ();

	generate
		if (P_VSHORT_MV >= P_VLOW_MV || P_ALERT_CYC < 2) begin : g_chk
			$error("cw_top: bad threshold or alert width parameter");
		end
	endgenerate

	// Charge-off pin: three stages, change taken when last two agree
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			sync_r <= 3'h7;
		else
			sync_r <= {sync_r[1:0], i_charge_off_pin};
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			off_q_r <= 1'b1;
			off_prev_r <= 1'b1;
		end else begin
			if (sync_r[1] == sync_r[2])
				off_q_r <= sync_r[2];
			off_prev_r <= off_q_r;
		end
	end

	assign permit = chg_en_r && !off_q_r; // [RULE7]
	assign start_ok = i_conv_ok && !i_thermistor_fault &&
		!safety_fault_r && permit; // [RULE9]
	assign rech_thr = charge_voltage_target_r -
		(rech_sel_r[0] ? RECH_OFS_HI : RECH_OFS_LO); // [RULE10]
	// Limit mode and disable bit both hold off termination
	assign term_det = (i_vbat_mv > rech_thr) && (i_ichg_ma < iterm_r) &&
		!i_reg_limit && term_en_r; // [RULE12] [RULE16] [RULE18]
	assign start_ph = (i_vbat_mv < P_VSHORT_MV) ? ST_TRK :
		(i_vbat_mv < P_VLOW_MV) ? ST_PRE : ST_FAST; // [RULE15]

	// Watchdog
	assign wd_if.clr = i_watchdog_kick || !host_mode_r; // [RULE5]
	assign wd_if.run = host_mode_r && (wd_sel_r != 2'h0);
	assign wd_if.half = 1'b0;
	assign wd_if.limit = cw_sel_ticks(wd_sel_r, WD_T1_S, WD_T2_S,
		WD_T3_S, TICKS_PER_S); // [RULE23]
	assign wd_exp = wd_if.run && wd_if.expired;

	// Safety timer, cleared off-charge, paused in supplement, halved in limit
	assign safety_if.clr = !cw_charging(phase_r);
	assign safety_if.run = cw_charging(phase_r) && !i_supplement;
	assign safety_if.half = i_reg_limit; // [RULE16]
	assign safety_if.limit = TW'(P_SAFETY_TICKS); // [RULE2]
	assign safety_exp = safety_if.run && safety_if.expired;

	// Top-off timer follows the safety timer's pause and rate
	assign top_if.clr = i_register_reset_bit ||
		(off_prev_r && !off_q_r) ||
		(phase_r == ST_TAPER && term_det); // [RULE21]
	assign top_if.run = (phase_r == ST_TOP) && !i_supplement; // [RULE20]
	assign top_if.half = i_reg_limit; // [RULE20]
	assign top_if.limit = top_lim_r;
	assign top_exp = top_if.run && top_if.expired;

	cw_timer #(.P_TICK_CYC(P_TICK_CYC)) u_wd (
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.t         (wd_if)
	);
	cw_timer #(.P_TICK_CYC(P_TICK_CYC)) u_safety (
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.t         (safety_if)
	);
	cw_timer #(.P_TICK_CYC(P_TICK_CYC)) u_top (
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.t         (top_if)
	);

	// Reset behaves as a watchdog expiry
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			host_mode_r <= 1'b0; // [RULE1]
			o_watchdog_expired_flag <= 1'b1;
		end else if (wd_exp) begin
			host_mode_r <= 1'b0; // [RULE6]
			o_watchdog_expired_flag <= 1'b1;
		end else if (i_watchdog_kick) begin
			host_mode_r <= 1'b1; // [RULE3]
			o_watchdog_expired_flag <= 1'b0;
		end
	end

	// Settings: defaults on reset, expiry or register reset
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			chg_en_r <= CHG_EN_RST; // [RULE1] [RULE8]
			term_en_r <= TERM_EN_RST;
			mask_r <= MASK_RST;
			temp_en_r <= TEMP_EN_RST;
			rech_sel_r <= RECH_SEL_RST;
			wd_sel_r <= WD_SEL_RST;
			top_sel_r <= TOP_SEL_RST;
			charge_voltage_target_r <= CHARGE_VOLTAGE_TARGET_RST;
			ichg_r <= ICHG_RST;
			ipre_r <= IPRE_RST;
			iterm_r <= ITERM_RST;
		end else if (wd_exp || i_register_reset_bit) begin
			chg_en_r <= CHG_EN_RST; // [RULE6] [RULE8]
			term_en_r <= TERM_EN_RST;
			mask_r <= MASK_RST;
			temp_en_r <= TEMP_EN_RST;
			rech_sel_r <= RECH_SEL_RST;
			wd_sel_r <= WD_SEL_RST;
			top_sel_r <= TOP_SEL_RST;
			charge_voltage_target_r <= CHARGE_VOLTAGE_TARGET_RST;
			ichg_r <= ICHG_RST;
			ipre_r <= IPRE_RST;
			iterm_r <= ITERM_RST;
		end else if (i_cfg_wr && host_mode_r) begin
			chg_en_r <= i_cfg_charge_enable_bit; // [RULE3]
			term_en_r <= i_cfg_termination_enable;
			mask_r <= i_cfg_phase_alert_mask;
			temp_en_r <= i_cfg_temp_profile_en;
			rech_sel_r <= i_cfg_recharge_offset_sel;
			wd_sel_r <= i_cfg_watchdog_period_sel;
			top_sel_r <= i_cfg_topoff_sel;
			charge_voltage_target_r <= i_cfg_charge_voltage_target;
			ichg_r <= i_cfg_ichg_ma;
			ipre_r <= i_cfg_iprechg_ma;
			iterm_r <= i_cfg_iterm_ma;
		end
	end

	// Phase sequencing
	always_comb begin
		phase_nxt = phase_r;
		unique case (phase_r)
			ST_IDLE:
				if (start_ok && (i_vbat_mv < charge_voltage_target_r || rearm_r))
					phase_nxt = start_ph; // [RULE9] [RULE11]
			ST_TRK, ST_PRE, ST_FAST, ST_TAPER, ST_TOP:
				if (!start_ok || safety_exp)
					phase_nxt = ST_IDLE; // [RULE2]
				else if (phase_r == ST_TRK && i_vbat_mv >= P_VSHORT_MV)
					phase_nxt = ST_PRE;
				else if (phase_r == ST_PRE && i_vbat_mv >= P_VLOW_MV)
					phase_nxt = ST_FAST;
				else if (phase_r == ST_FAST && i_vbat_mv >= charge_voltage_target_r)
					phase_nxt = ST_TAPER;
				else if (phase_r == ST_TAPER && term_det)
					phase_nxt = (top_sel_r != 2'h0) ?
						ST_TOP : ST_DONE; // [RULE19]
				else if (phase_r == ST_TOP && top_exp)
					phase_nxt = ST_DONE; // [RULE19]
			ST_DONE:
				if (!permit)
					phase_nxt = ST_IDLE;
				else if (start_ok && i_vbat_mv < rech_thr)
					phase_nxt = start_ph; // [RULE10]
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			phase_r <= ST_IDLE;
		else
			phase_r <= phase_nxt;
	end

	// Finished cycle plus enable toggle re-arms a start
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			rearm_r <= 1'b0;
		else if (phase_r == ST_DONE && !permit)
			rearm_r <= 1'b1; // [RULE11]
		else if (cw_charging(phase_r))
			rearm_r <= 1'b0;
	end

	// Safety fault holds until charging is toggled off
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			safety_fault_r <= 1'b0;
		else if (safety_exp)
			safety_fault_r <= 1'b1; // [RULE2]
		else if (!permit)
			safety_fault_r <= 1'b0;
	end

	// Top-off length frozen at termination detection
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			top_lim_r <= '0;
		else if (phase_r == ST_TAPER && term_det)
			top_lim_r <= cw_sel_ticks(top_sel_r, TOP_T1_MIN, TOP_T2_MIN,
				TOP_T3_MIN, 60 * TICKS_PER_S); // [RULE22]
	end

	// Alert pulse on phase change, completion included
	assign alert_trig = (cw_code(phase_nxt) != o_charge_phase_code) &&
		!mask_r; // [RULE14]

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			alert_cnt_r <= '0;
			o_host_alert_pin_n <= 1'b1;
		end else begin
			if (alert_trig)
				alert_cnt_r <= TW'(P_ALERT_CYC);
			else if (alert_cnt_r != '0)
				alert_cnt_r <= alert_cnt_r - TW'(1);
			o_host_alert_pin_n <= !(alert_trig ||
				alert_cnt_r > TW'(1)); // [RULE14]
		end
	end

	// Current request, reduced under limit
	always_comb begin
		unique case (phase_r)
			ST_TRK:                   iset = ISHORT_MA;
			ST_PRE:                   iset = ipre_r;
			ST_FAST, ST_TAPER, ST_TOP: iset = ichg_r;
			default:                  iset = '0;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_charge_phase_code <= CODE_IDLE;
			o_battery_switch_on <= 1'b0;
			o_conv_run <= 1'b0;
			o_host_mode <= 1'b0;
			o_safety_fault <= 1'b0;
			o_temp_profile_en <= TEMP_EN_RST;
			o_charge_voltage_target_mv <= CHARGE_VOLTAGE_TARGET_RST;
			o_ichg_target_ma <= '0;
		end else begin
			o_charge_phase_code <= cw_code(phase_nxt); // [RULE13]
			o_battery_switch_on <= cw_charging(phase_r) ||
				i_supplement; // [RULE17] [RULE2]
			o_conv_run <= 1'b1; // [RULE17]
			o_host_mode <= host_mode_r;
			o_safety_fault <= safety_fault_r;
			o_temp_profile_en <= temp_en_r;
			o_charge_voltage_target_mv <= charge_voltage_target_r;
			o_ichg_target_ma <= i_reg_limit ? (iset >> 1) : iset; // [RULE16]
		end
	end

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	kick_host_a: assert property (i_watchdog_kick && !wd_exp |=> // [RULE3]
		host_mode_r ##1 !o_watchdog_expired_flag && o_host_mode)
		else $error("kick did not enter host mode");
	wd_expire_a: assert property (wd_exp |=> // [RULE6]
		o_watchdog_expired_flag && !host_mode_r && chg_en_r == CHG_EN_RST)
		else $error("watchdog expiry did not restore default mode");
	permit_stop_a: assert property (cw_charging(phase_r) && !permit |=> // [RULE7]
		phase_r == ST_IDLE ##1 !o_battery_switch_on || i_supplement)
		else $error("charging continued without permit");
	term_block_a: assert property (phase_r == ST_TAPER && // [RULE12]
		(i_reg_limit || !term_en_r) |=> phase_r != ST_DONE &&
		phase_r != ST_TOP) else $error("termination while blocked");
	alert_pulse_a: assert property ($changed(o_charge_phase_code) && // [RULE14]
		!$past(mask_r) |-> !o_host_alert_pin_n ##1 !o_host_alert_pin_n)
		else $error("phase change without alert pulse");
	start_sel_a: assert property (phase_r == ST_IDLE && start_ok && // [RULE15]
		i_vbat_mv < P_VSHORT_MV && i_vbat_mv < charge_voltage_target_r |=>
		phase_r == ST_TRK ##1 o_charge_phase_code == CODE_TRK ||
		phase_r != ST_TRK) else $error("wrong start phase");
	recharge_a: assert property (phase_r == ST_DONE && start_ok && // [RULE10]
		i_vbat_mv < rech_thr |=> cw_charging(phase_r))
		else $error("recharge did not start");
	done_open_a: assert property (phase_r == ST_DONE && !i_supplement // [RULE17]
		|=> !o_battery_switch_on && o_conv_run)
		else $error("switch closed after termination");
	top_hold_a: assert property (phase_r == ST_TOP && // [RULE22]
		$past(phase_r) == ST_TOP |-> $stable(top_lim_r))
		else $error("top-off length changed after capture");
endmodule : cw_top

// ==== verif/cw_host_model.sv ====
// Host processor model issuing watchdog kicks and configuration writes
`timescale 1ns/1ns
module cw_host_model (
	// Clock
	input  wire logic        i_sys_clk,
	// Host writes
	output logic             o_kick,
	output logic             o_reg_rst,
	output logic             o_cfg_wr,
	output logic             o_mask,
	output logic             o_term_en,
	output logic [1:0]       o_rech_sel,
	output logic [1:0]       o_wd_sel,
	output logic [1:0]       o_top_sel,
	output logic [13:0]      o_charge_voltage_target_mv
);
	initial begin
		o_kick     = 1'h0;
		o_reg_rst  = 1'h0;
		o_cfg_wr   = 1'h0;
		o_mask     = 1'h0;
		o_term_en  = 1'h1;
		o_rech_sel = 2'h0;
		o_wd_sel   = 2'h1;
		o_top_sel  = 2'h0;
		o_charge_voltage_target_mv  = 14'h20d0;
	end

	// Kick restarts the device watchdog before it runs out
	task automatic do_kick();
		@(posedge i_sys_clk);
		o_kick <= 1'h1;
		@(posedge i_sys_clk);
		o_kick <= 1'h0;
	endtask : do_kick

	task automatic do_reg_rst();
		@(posedge i_sys_clk);
		o_reg_rst <= 1'h1;
		@(posedge i_sys_clk);
		o_reg_rst <= 1'h0;
	endtask : do_reg_rst

	// All fields written together in one pulse
	task automatic do_cfg(input logic [13:0] charge_voltage_target, input logic mask,
			input logic term, input logic [1:0] rech,
			input logic [1:0] top, input logic [1:0] wd);
		@(posedge i_sys_clk);
		o_cfg_wr   <= 1'h1;
		o_charge_voltage_target_mv  <= charge_voltage_target;
		o_mask     <= mask;
		o_term_en  <= term;
		o_rech_sel <= rech;
		o_top_sel  <= top;
		o_wd_sel   <= wd;
		@(posedge i_sys_clk);
		o_cfg_wr <= 1'h0;
	endtask : do_cfg
endmodule : cw_host_model

// ==== verif/test_charge_cycle_and_watchdog_control.sv ====
// Self-checking bench for the charge cycle and watchdog controller
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	fail_count++; $display("unexpected at %0t: got %h exp %h", $time, \
	(g), (e)); end end
module test_charge_cycle_and_watchdog_control;
	import cw_pkg::*;
	localparam int TK = 2;
	localparam int SF = 20;
	localparam int AL = 4;
	logic            clk = 1'h0;
	logic            rst = 1'h1;
	logic            pin = 1'h1;
	logic            conv_ok = 1'h1;
	logic            therm = 1'h0;
	logic            lim = 1'h0;
	logic            supp = 1'h0;
	logic            cen = 1'h1;
	logic            tpe = 1'h1;
	logic [2:0]      prev_code;
	int              alert_left;
	int              cur[3] = '{70, 150, 1000};
	logic [VW-1:0]   vbat = 14'h1b58;
	logic [IW-1:0]   ichg = 12'h1f4;
	logic            kick, rr, cwr, mask, term;
	logic [1:0]      rech, wd, top;
	logic [VW-1:0]   cvreg;
	logic [2:0]      code;
	logic            alert_n, sw, conv, flag, host, sfault, temp;
	logic [VW-1:0]   charge_voltage_target;
	logic [IW-1:0]   itgt;
	int              fail_count = 0;
	int              samples_checked = 0;
	logic [31:0]     lfsr = 32'h0001_3a5f;
	int              n;
	int              lo[3] = '{0, 3000, 6000};
	int              span[3] = '{2999, 2999, 2399};

	always #5 clk = ~clk;

	cw_host_model host_u (.i_sys_clk(clk), .o_kick(kick), .o_reg_rst(rr),
		.o_cfg_wr(cwr), .o_mask(mask), .o_term_en(term), .o_rech_sel(rech),
		.o_wd_sel(wd), .o_top_sel(top), .o_charge_voltage_target_mv(cvreg));

	cw_top #(.P_TICK_CYC(TK), .P_SAFETY_TICKS(SF), .P_ALERT_CYC(AL)) dut_u (
		.i_sys_clk(clk), .i_sys_rst(rst), .i_charge_off_pin(pin),
		.i_conv_ok(conv_ok), .i_thermistor_fault(therm), .i_reg_limit(lim),
		.i_supplement(supp), .i_vbat_mv(vbat), .i_ichg_ma(ichg),
		.i_watchdog_kick(kick), .i_register_reset_bit(rr), .i_cfg_wr(cwr),
		.i_cfg_charge_enable_bit(cen), .i_cfg_recharge_offset_sel(rech),
		.i_cfg_termination_enable(term), .i_cfg_phase_alert_mask(mask),
		.i_cfg_watchdog_period_sel(wd), .i_cfg_topoff_sel(top),
		.i_cfg_temp_profile_en(tpe), .i_cfg_charge_voltage_target(cvreg),
		.i_cfg_ichg_ma(12'h3e8), .i_cfg_iprechg_ma(12'h096),
		.i_cfg_iterm_ma(12'h096), .o_charge_phase_code(code),
		.o_host_alert_pin_n(alert_n), .o_battery_switch_on(sw),
		.o_conv_run(conv), .o_watchdog_expired_flag(flag),
		.o_host_mode(host), .o_safety_fault(sfault),
		.o_temp_profile_en(temp), .o_charge_voltage_target_mv(charge_voltage_target), .o_ichg_target_ma(itgt));

	// Reference model: start phase from battery voltage
	function automatic logic [2:0] exp_start(input int v);
		if (v < 3000)
			return CODE_TRK;
		if (v < 6000)
			return CODE_PRE;
		return CODE_FAST;
	endfunction : exp_start

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task automatic hold(input int k);
		repeat (k) @(negedge clk);
	endtask : hold

	task automatic wait_code(input logic [2:0] e);
		int k;
		k = 0;
		@(negedge clk);
		while (code !== e && k < 30) begin
			k++;
			@(negedge clk);
		end
		`CHK(code, e)
		if (k >= 30)
			end_sim();
	endtask : wait_code

	// Alert model: every code change asks for AL low cycles, restarted
	// by a further change; mask is the value the host last wrote
	always @(negedge clk) begin
		if (rst) begin
			prev_code = code;
			alert_left = 0;
		end else begin
			if (code !== prev_code && mask === 1'h0)
				alert_left = AL;
			prev_code = code;
			`CHK(alert_n, alert_left == 0)
			if (alert_left > 0)
				alert_left--;
		end
	end

	initial begin
		hold(4);
		`CHK({code, alert_n, sw, conv, flag, host}, 8'h12)
		`CHK({temp, charge_voltage_target}, {1'h1, CHARGE_VOLTAGE_TARGET_RST})
		@(posedge clk);
		rst <= 1'h0;
		hold(8);
		`CHK({code, conv}, 4'h1)
		for (int i = 0; i < 3; i++) begin
			lfsr = lfsr_next(lfsr);
			@(posedge clk);
			vbat <= VW'(lo[i] + int'(lfsr % 32'(span[i])));
			pin <= 1'h0;
			wait_code(exp_start(lo[i]));
			`CHK(alert_n, 1'h0)
			hold(2);
			`CHK(sw, 1'h1)
			`CHK(itgt, IW'(cur[i]))
			@(posedge clk);
			pin <= 1'h1;
			wait_code(CODE_IDLE);
		end
		@(posedge clk);
		vbat <= 14'h1b58;
		conv_ok <= 1'h0;
		pin <= 1'h0;
		hold(8);
		`CHK(code, CODE_IDLE)
		@(posedge clk);
		conv_ok <= 1'h1;
		wait_code(CODE_FAST);
		@(posedge clk);
		therm <= 1'h1;
		wait_code(CODE_IDLE);
		@(posedge clk);
		therm <= 1'h0;
		wait_code(CODE_FAST);
		@(posedge clk);
		vbat <= CHARGE_VOLTAGE_TARGET_RST;
		wait_code(CODE_TAPER);
		@(posedge clk);
		lim <= 1'h1;
		ichg <= 12'h064;
		hold(5);
		`CHK({code, itgt}, {CODE_TAPER, ICHG_RST >> 1})
		@(posedge clk);
		lim <= 1'h0;
		wait_code(CODE_DONE);
		`CHK(alert_n, 1'h0)
		hold(2);
		`CHK({sw, conv}, 2'h1)
		@(posedge clk);
		vbat <= CHARGE_VOLTAGE_TARGET_RST - RECH_OFS_LO + 14'h0032;
		supp <= 1'h1;
		hold(6);
		`CHK(code, CODE_DONE)
		@(posedge clk);
		vbat <= CHARGE_VOLTAGE_TARGET_RST - RECH_OFS_LO - 14'h0032;
		wait_code(CODE_FAST);
		@(posedge clk);
		vbat <= CHARGE_VOLTAGE_TARGET_RST;
		wait_code(CODE_DONE);
		hold(2);
		`CHK(sw, 1'h1)
		@(posedge clk);
		supp <= 1'h0;
		pin <= 1'h1;
		wait_code(CODE_IDLE);
		@(posedge clk);
		pin <= 1'h0;
		wait_code(CODE_FAST);
		@(posedge clk);
		vbat <= 14'h1b58;
		n = 0;
		while (sfault !== 1'h1 && n < 200) begin
			n++;
			@(negedge clk);
		end
		hold(2);
		`CHK({sfault, sw, conv}, 3'h5)
		if (n >= 200)
			end_sim();
		@(posedge clk);
		pin <= 1'h1;
		host_u.do_kick();
		hold(2);
		`CHK({host, flag}, 2'h2)
		host_u.do_cfg(14'h1f40, 1'h1, 1'h0, 2'h1, 2'h0, 2'h1);
		hold(2);
		`CHK(charge_voltage_target, 14'h1f40)
		@(posedge clk);
		pin <= 1'h0;
		wait_code(CODE_FAST);
		`CHK(alert_n, 1'h1)
		@(posedge clk);
		vbat <= 14'h1f40;
		hold(12);
		`CHK(code, CODE_TAPER)
		host_u.do_cfg(14'h1f40, 1'h0, 1'h1, 2'h1, 2'h0, 2'h1);
		wait_code(CODE_DONE);
		@(posedge clk);
		vbat <= 14'h1eaa;
		hold(6);
		`CHK(code, CODE_DONE)
		@(posedge clk);
		vbat <= 14'h1e6e;
		wait_code(CODE_FAST);
		host_u.do_cfg(14'h1f40, 1'h0, 1'h1, 2'h1, 2'h1, 2'h1);
		@(posedge clk);
		vbat <= 14'h1f40;
		wait_code(CODE_TOP);
		`CHK(alert_n, 1'h0)
		host_u.do_cfg(14'h1f40, 1'h0, 1'h1, 2'h1, 2'h0, 2'h1);
		hold(4);
		`CHK(code, CODE_TOP)
		@(posedge clk);
		cen <= 1'h0;
		tpe <= 1'h0;
		host_u.do_cfg(14'h1f40, 1'h0, 1'h1, 2'h1, 2'h0, 2'h1);
		wait_code(CODE_IDLE);
		`CHK(temp, 1'h0)
		host_u.do_reg_rst();
		hold(3);
		`CHK({temp, charge_voltage_target}, {1'h1, CHARGE_VOLTAGE_TARGET_RST})
		@(posedge clk);
		pin <= 1'h1;
		host_u.do_kick();
		n = 0;
		while (flag !== 1'h1 && n < 90000) begin
			n++;
			@(negedge clk);
		end
		`CHK(n >= WD_T1_S * TICKS_PER_S * TK - 10, 1'h1)
		`CHK(n <= WD_T1_S * TICKS_PER_S * TK + 10, 1'h1)
		if (n >= 90000)
			end_sim();
		hold(2);
		`CHK({flag, host, charge_voltage_target}, {2'h2, CHARGE_VOLTAGE_TARGET_RST})
		host_u.do_cfg(14'h1f40, 1'h0, 1'h1, 2'h0, 2'h0, 2'h1);
		hold(3);
		`CHK(charge_voltage_target, CHARGE_VOLTAGE_TARGET_RST)
		end_sim();
	end
endmodule : test_charge_cycle_and_watchdog_control
